/* File: hdl/sdram_ctrl.sv */
// Memory controller end driving the DRAM command and clock-enable pins
module sdram_ctrl
  import sdram_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  input wire req_t req_kind_in,
  input wire logic req_bank_in,
  input wire logic req_auto_precharge_in,
  input wire logic [10:0] req_addr_in,
  output logic req_ready_out,
  sdram_if.controller pins
);

  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic [11:0] addr;
    logic low_power;
  } ctrl_t;

  ctrl_t st;
  ctrl_t next_st;

  // In low power only the wake request is accepted; every request, wake included, is accepted otherwise
  always_comb begin
    req_ready_out = 1'b1;
    if (st.low_power && req_kind_in != req_wake) begin
      req_ready_out = 1'b0;
    end
  end

  // ----------------------------------------
  // Command issue
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Deselect fills the cycles between commands
    next_st.cmd = 4'hf;
    next_st.addr = 12'h000;
    if (req_valid_in && req_ready_out) begin
      next_st.addr = {req_bank_in, req_auto_precharge_in, req_addr_in[9:0]};
      case (req_kind_in)
        req_activate: begin
          next_st.cmd = bank_activate_command;
          next_st.addr = {req_bank_in, req_addr_in};
        end
        req_read: next_st.cmd = read_command;
        req_write: next_st.cmd = write_command;
        req_precharge: next_st.cmd = precharge_command;
        req_refresh: next_st.cmd = refresh_command;
        req_mode_set: next_st.cmd = mode_register_set_command;
        req_burst_stop: next_st.cmd = burst_stop_command;
        req_self_refresh: begin
          next_st.cmd = refresh_command;
          next_st.cke = 1'b0;
          next_st.low_power = 1'b1;
        end
        req_power_down: begin
          next_st.cke = 1'b0;
          next_st.low_power = 1'b1;
        end
        req_suspend: begin
          next_st.cke = 1'b0;
          next_st.low_power = 1'b1;
        end
        req_wake: begin
          next_st.cmd = no_operation_command;
          next_st.cke = 1'b1;
          next_st.low_power = 1'b0;
        end
        default: begin
          next_st.cmd = no_operation_command;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '{cke: 1'b1, cmd: 4'hf, addr: 12'h000, low_power: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pins.cke = st.cke;
  assign pins.cs_n = st.cmd[3];
  assign pins.ras_n = st.cmd[2];
  assign pins.cas_n = st.cmd[1];
  assign pins.we_n = st.cmd[0];
  assign pins.addr = st.addr;

endmodule : sdram_ctrl

/* File: hdl/sdram_dev.sv */
// DRAM end: command decode, clock-enable state and per-bank state tracking
//
// Function
// - Self-refresh exit needs deselect or no-operation
// - Recovery returns idle after row cycle time
// - Clock-enable drop in recovery enters power-down
// - Clock-enable rise leaves power-down to idle
// - Idle decode: nop, activate/precharge, refresh, mode
// - Both banks idle: clock-enable drop enters self-refresh on refresh, else power-down
// - Clock-enable drop elsewhere suspends internal clock
// - Clock-enable rise ends suspend next cycle
// - Suspend entry command must be legal (not checked here: suspend entry never sets the illegal flag)
// - Activate opens row in selected bank
// - Read/write chooses plain or auto-precharge state
// - Inputs captured only on rising clock edge
// - Two address bits below auto-precharge ignored
module sdram_dev
  import sdram_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  sdram_if.device pins,
  output bank_state_t bank0_state_out,
  output bank_state_t bank1_state_out,
  output dev_state_t dev_state_out,
  output logic [10:0] open_row0_out,
  output logic [10:0] open_row1_out,
  output logic [7:0] column_out,
  output logic column_valid_out,
  output logic [11:0] mode_op_out,
  output logic illegal_out
);

  typedef struct packed {
    logic cke_prev;
    dev_state_t dev;
    bank_state_t [1:0] bank;
    logic [1:0][10:0] row;
    logic [7:0] column;
    logic column_valid;
    logic [11:0] mode_op;
    logic illegal;
    logic [3:0] rc_count;
    logic cke;
    logic [3:0] cmd;
    logic [11:0] addr;
  } dev_t;

  dev_t st;
  dev_t next_st;
  logic nop_like;
  logic both_idle;
  logic bsel;
  logic ap;

  // ----------------------------------------
  // Decode of the captured pins
  // ----------------------------------------
  assign nop_like = st.cmd[3] || st.cmd[2] && st.cmd[1];
  assign both_idle = st.bank[0] == bank_idle && st.bank[1] == bank_idle;
  assign bsel = st.addr[bank_select_pos];
  assign ap = st.addr[auto_precharge_pos];

  always_comb begin
    next_st = st;
    next_st.cke = pins.cke;
    next_st.cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    next_st.addr = pins.addr;
    next_st.cke_prev = st.cke;
    next_st.column_valid = 1'b0;
    next_st.illegal = 1'b0;
    if (st.rc_count != 4'h0) begin
      next_st.rc_count = st.rc_count - 4'h1;
    end
    case (st.dev)
      dev_self_refresh: begin
        if (!st.cke_prev && st.cke) begin
          if (nop_like) begin
            next_st.dev = dev_sr_recovery;
            next_st.rc_count = 4'(row_cycle_cycles);
          end else begin
            next_st.illegal = 1'b1;
          end
        end else if (st.cke_prev) begin
          next_st.illegal = 1'b1;
        end
      end
      dev_sr_recovery: begin
        if (!st.cke_prev && !st.cke) begin
          next_st.dev = dev_sr_recovery;
        end else if (!nop_like && st.cke_prev) begin
          next_st.illegal = 1'b1;
        end else if (st.cke_prev && !st.cke) begin
          next_st.dev = dev_power_down;
        end else if (st.cke_prev && st.rc_count <= 4'h1) begin
          next_st.dev = dev_normal;
        end
      end
      dev_power_down: begin
        if (!st.cke_prev && st.cke) begin
          next_st.dev = dev_normal;
        end else if (st.cke_prev) begin
          next_st.illegal = 1'b1;
        end
      end
      dev_suspend: begin
        if (st.cke) begin
          next_st.dev = dev_normal;
        end
      end
      dev_normal: begin
        if (st.cke_prev && !st.cke) begin
          if (!both_idle) begin
            next_st.dev = dev_suspend;
          end else if (st.cmd == refresh_command) begin
            next_st.dev = dev_self_refresh;
          end else begin
            next_st.dev = dev_power_down;
          end
        end else if (st.cke_prev && st.cke && !st.cmd[3]) begin
          case (st.cmd)
            bank_activate_command: begin
              if (st.bank[bsel] == bank_idle) begin
                next_st.bank[bsel] = bank_active;
                next_st.row[bsel] = st.addr[row_width-1:0];
              end else begin
                next_st.illegal = 1'b1;
              end
            end
            read_command, write_command: begin
              if (st.bank[bsel] == bank_idle) begin
                next_st.illegal = 1'b1;
              end else begin
                next_st.column = st.addr[col_width-1:0];
                next_st.column_valid = 1'b1;
                if (st.cmd == read_command) begin
                  next_st.bank[bsel] = ap ? read_with_autoprecharge_state : bank_read;
                end else begin
                  next_st.bank[bsel] = ap ? write_with_autoprecharge_state : bank_write;
                end
                if (st.bank[!bsel] == bank_read || st.bank[!bsel] == bank_write) begin
                  next_st.bank[!bsel] = bank_active;
                end
              end
            end
            precharge_command: begin
              if (ap) begin
                next_st.bank[0] = bank_idle;
                next_st.bank[1] = bank_idle;
              end else begin
                next_st.bank[bsel] = bank_idle;
              end
            end
            burst_stop_command: begin
              for (int b = 0; b < 2; b++) begin
                if (st.bank[b] == bank_read || st.bank[b] == bank_write) begin
                  next_st.bank[b] = bank_active;
                end
              end
            end
            refresh_command: begin
              next_st.illegal = !both_idle;
            end
            mode_register_set_command: begin
              if (both_idle) begin
                next_st.mode_op = st.addr;
              end else begin
                next_st.illegal = 1'b1;
              end
            end
            default: begin
              next_st.illegal = 1'b0;
            end
          endcase
        end
      end
      default: begin
        next_st.dev = dev_normal;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '{cke_prev: 1'b1, dev: dev_normal, bank: '{bank_idle, bank_idle}, row: '0,
              column: 8'h00, column_valid: 1'b0, mode_op: 12'h000, illegal: 1'b0,
              rc_count: 4'h0, cke: 1'b1, cmd: 4'h7, addr: 12'h000};
    end else begin
      st <= next_st;
    end
  end

  assign bank0_state_out = st.bank[0];
  assign bank1_state_out = st.bank[1];
  assign dev_state_out = st.dev;
  assign open_row0_out = st.row[0];
  assign open_row1_out = st.row[1];
  assign column_out = st.column;
  assign column_valid_out = st.column_valid;
  assign mode_op_out = st.mode_op;
  assign illegal_out = st.illegal;

endmodule : sdram_dev

/* File: inc/sdram_if.sv */
// Interface joining the memory controller to the DRAM command pins
interface sdram_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [11:0] addr;

  modport controller (
    output cke, cs_n, ras_n, cas_n, we_n, addr
  );

  modport device (
    input cke, cs_n, ras_n, cas_n, we_n, addr
  );
endinterface : sdram_if

/* File: inc/sdram_pkg.sv */
// Package of shared constants and types for the DRAM command and clock-enable logic
package sdram_pkg;

  localparam int unsigned addr_width = 12;
  localparam int unsigned auto_precharge_pos = 10;
  localparam int unsigned bank_select_pos = 11;
  localparam int unsigned row_width = 11;
  localparam int unsigned col_width = 8;

  // Row cycle time and its count at 40 MHz
  localparam int unsigned clk_period_ps = 25000;
  localparam int unsigned row_cycle_time_ps = 60000;
  localparam int unsigned row_cycle_cycles = (row_cycle_time_ps + clk_period_ps - 1) / clk_period_ps;
  localparam int unsigned cnt_width = 4;

  // Command code on {cs, ras, cas, we}, all active low
  typedef enum logic [3:0] {
    no_operation_command = 4'h7,
    burst_stop_command = 4'h6,
    read_command = 4'h5,
    write_command = 4'h4,
    bank_activate_command = 4'h3,
    precharge_command = 4'h2,
    refresh_command = 4'h1,
    mode_register_set_command = 4'h0
  } cmd_t;

  // Per-bank state
  typedef enum logic [5:0] {
    bank_idle = 6'h01,
    bank_active = 6'h02,
    bank_read = 6'h04,
    bank_write = 6'h08,
    read_with_autoprecharge_state = 6'h10,
    write_with_autoprecharge_state = 6'h20
  } bank_state_t;

  // Clock-enable related device state
  typedef enum logic [4:0] {
    dev_normal = 5'h01,
    dev_self_refresh = 5'h02,
    dev_sr_recovery = 5'h04,
    dev_power_down = 5'h08,
    dev_suspend = 5'h10
  } dev_state_t;

  // Controller request kinds
  typedef enum logic [3:0] {
    req_nop = 4'h0,
    req_activate = 4'h1,
    req_read = 4'h2,
    req_write = 4'h3,
    req_precharge = 4'h4,
    req_refresh = 4'h5,
    req_mode_set = 4'h6,
    req_burst_stop = 4'h7,
    req_self_refresh = 4'h8,
    req_power_down = 4'h9,
    req_suspend = 4'ha,
    req_wake = 4'hb
  } req_t;

endpackage : sdram_pkg

/* File: tb/sdram_pin_checker.sv */
// Checker of command and clock-enable rules on the DRAM pins
module sdram_pin_checker
  import sdram_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [11:0] addr_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Pin tracking
  // ----------------------------------------
  logic [3:0] cmd;
  logic nop_c;
  logic cke_q;
  logic in_sr;
  logic [1:0] open;
  logic hh;
  logic cke;
  logic [11:0] addr;
  assign cke = cke_in;
  assign addr = addr_in;
  assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  assign nop_c = cs_n_in || ras_n_in && cas_n_in;
  assign hh = cke && cke_q;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cke_q <= 1'b1;
      in_sr <= 1'b0;
      open <= 2'h0;
    end else begin
      cke_q <= cke;
      if (cke_q && !cke && cmd == refresh_command) in_sr <= 1'b1;
      else if (!cke_q && cke) in_sr <= 1'b0;
      if (hh && cmd == bank_activate_command) open[addr[11]] <= 1'b1;
      else if (hh && cmd == precharge_command && addr[10]) open <= 2'h0;
      else if (hh && (cmd == precharge_command || addr[10] && cmd inside {read_command, write_command}))
        open[addr[11]] <= 1'b0;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence sr_wake_s;
    in_sr && !cke_q && cke;
  endsequence
  sequence sr_enter_s;
    cke_q && !cke && cmd == refresh_command;
  endsequence
  sr_exit_cmd_a: assert property (sr_wake_s |-> nop_c)
    else $error("bad command at self-refresh exit");
  recovery_nop_a: assert property (sr_wake_s |=> nop_c [*2])
    else $error("command during self-refresh recovery");
  sr_entry_idle_a: assert property (sr_enter_s |-> open == 2'h0)
    else $error("self-refresh entered with open bank");
  sr_stay_a: assert property (sr_enter_s |=> !cke)
    else $error("clock enable rose right after self-refresh entry");
  suspend_cmd_a: assert property (cke_q && !cke && open != 2'h0 |->
    !(cmd inside {refresh_command, mode_register_set_command}))
    else $error("illegal command at suspend entry");
  act_idle_a: assert property (cke && cmd == bank_activate_command |-> !open[addr[11]])
    else $error("activate to open bank");
  rw_open_a: assert property (cke && cmd inside {read_command, write_command} |-> open[addr[11]])
    else $error("read or write to idle bank");
  mode_idle_a: assert property (cke && cmd == mode_register_set_command |-> open == 2'h0)
    else $error("mode set with open bank");
endmodule : sdram_pin_checker

/* File: tb/tb_sdram_cke_and_bank_state_logic.sv */
// Testbench joining controller and device ends with a behavioural state model
module tb_sdram_cke_and_bank_state_logic
  import sdram_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 0, resetn_in = 0, req_valid_in = 0, req_bank_in = 0, req_auto_precharge_in = 0;
  req_t req_kind_in = req_nop;
  logic [10:0] req_addr_in = '0, r0, r1, row;
  logic req_ready_out, b;
  logic [7:0] col;
  bank_state_t b0, b1, bs[2];
  dev_state_t dv, dm;
  logic cv, ill, bad_cmd = 1'b0;
  logic [11:0] mop;
  int n_mismatch = 0, n_compared = 0, cyc = 0, n_col = 0;
  sdram_if pins();
  sdram_ctrl u_sdram_ctrl (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in),
    .req_kind_in(req_kind_in), .req_bank_in(req_bank_in), .req_auto_precharge_in(req_auto_precharge_in),
    .req_addr_in(req_addr_in), .req_ready_out(req_ready_out), .pins(pins));
  sdram_dev u_sdram_dev (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .pins(pins), .bank0_state_out(b0),
    .bank1_state_out(b1), .dev_state_out(dv), .open_row0_out(r0), .open_row1_out(r1), .column_out(col),
    .column_valid_out(cv), .mode_op_out(mop), .illegal_out(ill));
  sdram_pin_checker u_sdram_pin_checker (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cke_in(pins.cke),
    .cs_n_in(pins.cs_n), .ras_n_in(pins.ras_n), .cas_n_in(pins.cas_n), .we_n_in(pins.we_n),
    .addr_in(pins.addr));
  // ----------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------
  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  always @(negedge ref_clk_in) begin
    if (resetn_in && ill !== 1'b0) bad_cmd <= 1'b1;
    if (resetn_in && cv === 1'b1) n_col <= n_col + 1;
  end
  task complete_run();
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task cmp_s(logic [5:0] g, logic [5:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t state %h expected %h", $time, g, e);
    end
  endtask : cmp_s
  task cmp_v(logic [11:0] g, logic [11:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask : cmp_v
  // Issue one request, wait for decode, compare all states with the model
  task rq(req_t k, logic bk, logic ap, logic [10:0] a);
    int i;
    @(negedge ref_clk_in);
    req_kind_in = k;
    req_bank_in = bk;
    req_auto_precharge_in = ap;
    req_addr_in = a;
    req_valid_in = 1;
    for (i = 0; i < 50 && req_ready_out !== 1'b1; i++) @(negedge ref_clk_in);
    if (i == 50) n_mismatch++;
    @(negedge ref_clk_in);
    req_valid_in = 0;
    repeat (3) @(negedge ref_clk_in);
    cmp_s(b0, bs[0]);
    cmp_s(b1, bs[1]);
    cmp_s({1'b0, dv}, {1'b0, dm});
  endtask : rq
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h5f1d));
    repeat (3) @(negedge ref_clk_in);
    resetn_in = 1;
    bs[0] = bank_idle;
    bs[1] = bank_idle;
    dm = dev_normal;
    repeat (6) begin
      b = 1'($urandom);
      row = 11'($urandom);
      bs[b] = bank_active;
      rq(req_activate, b, 0, row);
      cmp_v({1'b0, b ? r1 : r0}, {1'b0, row});
      bs[b] = bank_write;
      rq(req_write, b, 0, row);
      cmp_v({4'h0, col}, {4'h0, row[7:0]});
      bs[!b] = bank_active;
      rq(req_activate, !b, 0, row);
      bs[!b] = bank_read;
      bs[b] = bank_active;
      rq(req_read, !b, 0, row);
      bs[!b] = bank_active;
      rq(req_burst_stop, !b, 0, 11'h000);
      bs[b] = bank_idle;
      rq(req_precharge, b, 0, 11'h000);
      bs[!b] = read_with_autoprecharge_state;
      rq(req_read, !b, 1, row);
      bs[!b] = bank_idle;
      rq(req_precharge, b, 1, 11'h000);
    end
    rq(req_mode_set, b, 1, row);
    cmp_v(mop, {b, 1'b1, row[9:0]});
    rq(req_refresh, 0, 0, 11'h000);
    dm = dev_self_refresh;
    rq(req_self_refresh, 0, 0, 11'h000);
    dm = dev_sr_recovery;
    rq(req_wake, 0, 0, 11'h000);
    repeat (4) @(negedge ref_clk_in);
    cmp_s({1'b0, dv}, {1'b0, dev_normal});
    dm = dev_power_down;
    rq(req_power_down, 0, 0, 11'h000);
    dm = dev_normal;
    rq(req_wake, 0, 0, 11'h000);
    dm = dev_self_refresh;
    rq(req_self_refresh, 0, 0, 11'h000);
    @(negedge ref_clk_in);
    req_kind_in = req_wake;
    req_valid_in = 1;
    @(negedge ref_clk_in);
    req_kind_in = req_power_down;
    @(negedge ref_clk_in);
    req_valid_in = 0;
    @(negedge ref_clk_in);
    cmp_s({1'b0, dv}, {1'b0, dev_sr_recovery});
    @(negedge ref_clk_in);
    cmp_s({1'b0, dv}, {1'b0, dev_power_down});
    dm = dev_normal;
    rq(req_wake, 0, 0, 11'h000);
    bs[1] = bank_active;
    rq(req_activate, 1, 0, row);
    dm = dev_suspend;
    rq(req_suspend, 0, 0, 11'h000);
    dm = dev_normal;
    rq(req_wake, 0, 0, 11'h000);
    cmp_v(12'(n_col), 12'h012);
    cmp_v({11'h000, bad_cmd}, 12'h000);
    complete_run();
  end
endmodule : tb_sdram_cke_and_bank_state_logic
